/* hdl/exec_pkg.sv */
// constants, types and helpers shared by the bit, flag and data-transfer execution unit
package exec_pkg;
	localparam int REG_COUNT = 32;
	localparam logic [4:0] REGISTER_ZERO = 5'h00;
	localparam logic [4:0] PTR_BASE_INDEX = 5'h1A;
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;
	localparam logic [1:0] PTR_NONE = 2'h3;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h00FF;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	localparam int CYCLES_FLAG_OP = 1;
	localparam int CYCLES_DATA_OP = 2;
	localparam int CYCLES_PROGRAM_READ = 3;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_BIT_TO_TRANSFER_FLAG = 5'h01,
		OP_TRANSFER_FLAG_TO_BIT = 5'h02,
		OP_SET_HALF_CARRY = 5'h03,
		OP_CLEAR_HALF_CARRY = 5'h04,
		OP_SET_OVERFLOW_FLAG = 5'h05,
		OP_CLEAR_OVERFLOW_FLAG = 5'h06,
		OP_SET_SIGN_FLAG = 5'h07,
		OP_CLEAR_SIGN_FLAG = 5'h08,
		OP_INDIRECT_LOAD = 5'h09,
		OP_INDIRECT_LOAD_INC = 5'h0A,
		OP_INDIRECT_LOAD_DEC = 5'h0B,
		OP_DISPLACED_LOAD = 5'h0C,
		OP_INDIRECT_STORE = 5'h0D,
		OP_INDIRECT_STORE_INC = 5'h0E,
		OP_INDIRECT_STORE_DEC = 5'h0F,
		OP_DISPLACED_STORE = 5'h10,
		OP_DIRECT_LOAD = 5'h11,
		OP_DIRECT_STORE = 5'h12,
		OP_PROGRAM_MEMORY_READ_ZERO = 5'h13,
		OP_PROGRAM_MEMORY_READ = 5'h14,
		OP_PROGRAM_MEMORY_READ_INC = 5'h15,
		OP_PUSH = 5'h16,
		OP_POP = 5'h17,
		OP_SLEEP = 5'h18,
		OP_WATCHDOG_RESTART = 5'h19,
		OP_BREAK = 5'h1A
	} op_type;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_DATA = 4'h2,
		S_PROG_A = 4'h4,
		S_PROG_B = 4'h8
	} state_type;

	// 16-bit step with carry or borrow across the byte pair
	function automatic logic [15:0] word_step(input logic [15:0] v, input logic down);
		word_step = down ? v - WORD_ONE : v + WORD_ONE;
	endfunction

	function automatic logic [4:0] ptr_low_index(input logic [1:0] sel);
		ptr_low_index = PTR_BASE_INDEX + {2'h0, sel, 1'b0};
	endfunction

	function automatic logic is_data_op(input op_type op);
		is_data_op = op inside {[OP_INDIRECT_LOAD:OP_DIRECT_STORE], OP_PUSH, OP_POP};
	endfunction

	function automatic logic is_store_op(input op_type op);
		is_store_op = op inside {[OP_INDIRECT_STORE:OP_DISPLACED_STORE], OP_DIRECT_STORE,
			OP_PUSH};
	endfunction

	function automatic logic uses_pointer(input op_type op);
		uses_pointer = op inside {[OP_INDIRECT_LOAD:OP_DISPLACED_STORE]};
	endfunction

	function automatic logic is_displaced(input op_type op);
		is_displaced = op inside {OP_DISPLACED_LOAD, OP_DISPLACED_STORE};
	endfunction

	function automatic logic is_pre_dec(input op_type op);
		is_pre_dec = op inside {OP_INDIRECT_LOAD_DEC, OP_INDIRECT_STORE_DEC};
	endfunction

	function automatic logic is_post_inc(input op_type op);
		is_post_inc = op inside {OP_INDIRECT_LOAD_INC, OP_INDIRECT_STORE_INC};
	endfunction
endpackage

/* hdl/transfer_addr_gen.sv */
// data-space address generation for pointer, displaced, direct and stack transfers
module transfer_addr_gen
	import exec_pkg::*;
(
	input exec_pkg::op_type op,
	input logic [15:0] ptr,
	input logic [5:0] disp,
	input logic [15:0] direct_addr,
	input logic [15:0] sp,
	output logic [15:0] mem_addr,
	output logic [15:0] ptr_dec,
	output logic [15:0] sp_next
);
	always_comb begin
		ptr_dec = word_step(ptr, 1'b1);
		sp_next = sp;
		case (op)
			OP_INDIRECT_LOAD_DEC, OP_INDIRECT_STORE_DEC: mem_addr = ptr_dec;
			OP_DISPLACED_LOAD, OP_DISPLACED_STORE: mem_addr = ptr + {10'h000, disp};
			OP_DIRECT_LOAD, OP_DIRECT_STORE: mem_addr = direct_addr;
			OP_PUSH: begin
				// write at the current top, then move down
				mem_addr = sp;
				sp_next = word_step(sp, 1'b1);
			end
			OP_POP: begin
				sp_next = word_step(sp, 1'b0);
				mem_addr = sp_next;
			end
			default: mem_addr = ptr;
		endcase
	end
endmodule

/* hdl/bit_transfer_exec.sv */
// execution unit for flag, bit-move, data-transfer and core-control operations
module bit_transfer_exec (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input exec_pkg::op_type op,
	input wire logic [4:0] reg_sel,
	input wire logic [2:0] bit_sel,
	input wire logic [1:0] ptr_sel,
	input wire logic [5:0] disp,
	input wire logic [15:0] direct_addr,
	input wire logic debug_en,
	input wire logic host_wr_en,
	input wire logic [4:0] host_wr_idx,
	input wire logic [7:0] host_wr_data,
	input wire logic [4:0] peek_idx,
	input wire logic [7:0] dmem_rdata,
	input wire logic [7:0] pmem_rdata,
	output logic busy_q,
	output logic done_q,
	output logic illegal_q,
	output logic [7:0] status_flags_register_q,
	output logic [15:0] sp_q,
	output logic [7:0] peek_data_q,
	output logic [15:0] dmem_addr_q,
	output logic [7:0] dmem_wdata_q,
	output logic dmem_we_q,
	output logic dmem_re_q,
	output logic [15:0] pmem_addr_q,
	output logic pmem_re_q,
	output logic sleep_q,
	output logic watchdog_restart_q,
	output logic break_q
);
	import exec_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	state_type state_q, state_d;
	op_type op_q, op_d;
	logic [4:0] dest_q, dest_d;
	logic [1:0] psel_q, psel_d;
	logic [7:0] regs_q [REG_COUNT];
	logic [7:0] regs_d [REG_COUNT];
	logic [7:0] flags_d;
	logic [15:0] sp_d;
	logic busy_d, done_d, illegal_d;
	logic [7:0] peek_d;
	logic [15:0] dmem_addr_d;
	logic [7:0] dmem_wdata_d;
	logic dmem_we_d, dmem_re_d;
	logic [15:0] pmem_addr_d;
	logic pmem_re_d;
	logic sleep_d, wdr_d, break_d;
	logic accept;
	logic ptr_ok;
	logic [4:0] cur_lo, lat_lo, z_lo;
	logic [15:0] cur_ptr, lat_ptr, z_ptr, lat_next, z_next;
	logic [15:0] gen_addr, gen_ptr_dec, gen_sp;

	assign accept = ce && start && !busy_q;
	assign cur_lo = ptr_low_index(ptr_sel);
	assign lat_lo = ptr_low_index(psel_q);
	assign z_lo = ptr_low_index(PTR_Z);
	assign cur_ptr = {regs_q[{cur_lo[4:1], 1'b1}], regs_q[cur_lo]};
	assign lat_ptr = {regs_q[{lat_lo[4:1], 1'b1}], regs_q[lat_lo]};
	assign z_ptr = {regs_q[{z_lo[4:1], 1'b1}], regs_q[z_lo]};
	assign lat_next = word_step(lat_ptr, 1'b0);
	assign z_next = word_step(z_ptr, 1'b0);
	// displaced forms exist only on Y and Z
	assign ptr_ok = !uses_pointer(op) ||
		(ptr_sel != PTR_NONE && !(is_displaced(op) && ptr_sel == PTR_X));

	transfer_addr_gen u_addr_gen (
		.op(op),
		.ptr(cur_ptr),
		.disp(disp),
		.direct_addr(direct_addr),
		.sp(sp_q),
		.mem_addr(gen_addr),
		.ptr_dec(gen_ptr_dec),
		.sp_next(gen_sp)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		dest_d = dest_q;
		psel_d = psel_q;
		regs_d = regs_q;
		flags_d = status_flags_register_q;
		sp_d = sp_q;
		busy_d = busy_q;
		done_d = 1'b0;
		illegal_d = 1'b0;
		peek_d = regs_q[peek_idx];
		dmem_addr_d = dmem_addr_q;
		dmem_wdata_d = dmem_wdata_q;
		dmem_we_d = 1'b0;
		dmem_re_d = 1'b0;
		pmem_addr_d = pmem_addr_q;
		pmem_re_d = 1'b0;
		sleep_d = 1'b0;
		wdr_d = 1'b0;
		break_d = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (accept) begin
					op_d = op;
					dest_d = reg_sel;
					psel_d = ptr_sel;
					done_d = 1'b1;
					case (op)
						OP_BIT_TO_TRANSFER_FLAG: flags_d[FLAG_T] = regs_q[reg_sel][bit_sel];
						OP_TRANSFER_FLAG_TO_BIT: begin
							regs_d[reg_sel][bit_sel] = status_flags_register_q[FLAG_T];
						end
						OP_SET_HALF_CARRY: flags_d[FLAG_H] = 1'b1;
						OP_CLEAR_HALF_CARRY: flags_d[FLAG_H] = 1'b0;
						OP_SET_OVERFLOW_FLAG: flags_d[FLAG_V] = 1'b1;
						OP_CLEAR_OVERFLOW_FLAG: flags_d[FLAG_V] = 1'b0;
						OP_SET_SIGN_FLAG: flags_d[FLAG_S] = 1'b1;
						OP_CLEAR_SIGN_FLAG: flags_d[FLAG_S] = 1'b0;
						OP_SLEEP: sleep_d = 1'b1;
						OP_WATCHDOG_RESTART: wdr_d = 1'b1;
						OP_BREAK: break_d = debug_en;
						OP_PROGRAM_MEMORY_READ_ZERO, OP_PROGRAM_MEMORY_READ,
						OP_PROGRAM_MEMORY_READ_INC: begin
							pmem_addr_d = z_ptr;
							pmem_re_d = 1'b1;
							busy_d = 1'b1;
							done_d = 1'b0;
							state_d = S_PROG_A;
						end
						default: begin
							if (is_data_op(op) && !ptr_ok) begin
								illegal_d = 1'b1;
							end else if (is_data_op(op)) begin
								dmem_addr_d = gen_addr;
								dmem_wdata_d = regs_q[reg_sel];
								dmem_we_d = is_store_op(op);
								dmem_re_d = !is_store_op(op);
								sp_d = gen_sp;
								if (is_pre_dec(op)) begin
									regs_d[cur_lo] = gen_ptr_dec[7:0];
									regs_d[{cur_lo[4:1], 1'b1}] = gen_ptr_dec[15:8];
								end
								busy_d = 1'b1;
								done_d = 1'b0;
								state_d = S_DATA;
							end
						end
					endcase
				end else if (ce && host_wr_en) begin
					regs_d[host_wr_idx] = host_wr_data;
				end
			end
			S_DATA: begin
				if (is_post_inc(op_q)) begin
					regs_d[lat_lo] = lat_next[7:0];
					regs_d[{lat_lo[4:1], 1'b1}] = lat_next[15:8];
				end
				// a loaded byte wins over a pointer step into the same register
				if (!is_store_op(op_q)) begin
					regs_d[dest_q] = dmem_rdata;
				end
				busy_d = 1'b0;
				done_d = 1'b1;
				state_d = S_IDLE;
			end
			S_PROG_A: begin
				pmem_re_d = 1'b1;
				state_d = S_PROG_B;
			end
			S_PROG_B: begin
				if (op_q == OP_PROGRAM_MEMORY_READ_INC) begin
					regs_d[z_lo] = z_next[7:0];
					regs_d[{z_lo[4:1], 1'b1}] = z_next[15:8];
				end
				if (op_q == OP_PROGRAM_MEMORY_READ_ZERO) begin
					regs_d[REGISTER_ZERO] = pmem_rdata;
				end else begin
					regs_d[dest_q] = pmem_rdata;
				end
				busy_d = 1'b0;
				done_d = 1'b1;
				state_d = S_IDLE;
			end
			default: begin
				busy_d = 1'b0;
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			op_q <= OP_NOP;
			dest_q <= REGISTER_ZERO;
			psel_q <= PTR_X;
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= REG_RESET;
			end
			status_flags_register_q <= FLAGS_RESET;
			sp_q <= SP_RESET;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			peek_data_q <= REG_RESET;
			dmem_addr_q <= 16'h0000;
			dmem_wdata_q <= 8'h00;
			dmem_we_q <= 1'b0;
			dmem_re_q <= 1'b0;
			pmem_addr_q <= 16'h0000;
			pmem_re_q <= 1'b0;
			sleep_q <= 1'b0;
			watchdog_restart_q <= 1'b0;
			break_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			op_q <= op_d;
			dest_q <= dest_d;
			psel_q <= psel_d;
			regs_q <= regs_d;
			status_flags_register_q <= flags_d;
			sp_q <= sp_d;
			busy_q <= busy_d;
			done_q <= done_d;
			illegal_q <= illegal_d;
			peek_data_q <= peek_d;
			dmem_addr_q <= dmem_addr_d;
			dmem_wdata_q <= dmem_wdata_d;
			dmem_we_q <= dmem_we_d;
			dmem_re_q <= dmem_re_d;
			pmem_addr_q <= pmem_addr_d;
			pmem_re_q <= pmem_re_d;
			sleep_q <= sleep_d;
			watchdog_restart_q <= wdr_d;
			break_q <= break_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks assume ce held high across an operation
	logic src_bit;
	logic [15:0] x_ptr;
	assign src_bit = regs_q[reg_sel][bit_sel];
	assign x_ptr = {regs_q[PTR_BASE_INDEX + 5'h01], regs_q[PTR_BASE_INDEX]};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	property p_bit_store;
		accept && op == OP_BIT_TO_TRANSFER_FLAG |=>
			status_flags_register_q[FLAG_T] == $past(src_bit) && done_q &&
			status_flags_register_q[5:0] == $past(status_flags_register_q[5:0]);
	endproperty
	a_bit_store: assert property (p_bit_store) else $error("bit store wrong");
	property p_bit_load;
		accept && op == OP_TRANSFER_FLAG_TO_BIT |=> $stable(status_flags_register_q) && done_q;
	endproperty
	a_bit_load: assert property (p_bit_load) else $error("bit load moved flags");
	property p_half_carry;
		accept && op inside {OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY} |=>
			status_flags_register_q[FLAG_H] == ($past(op) == OP_SET_HALF_CARRY) &&
			((status_flags_register_q ^ $past(status_flags_register_q)) & 8'hDF) == 8'h00;
	endproperty
	a_half_carry: assert property (p_half_carry) else $error("half carry op wrong");
	property p_overflow;
		accept && op inside {OP_SET_OVERFLOW_FLAG, OP_CLEAR_OVERFLOW_FLAG} |=>
			status_flags_register_q[FLAG_V] == ($past(op) == OP_SET_OVERFLOW_FLAG) &&
			((status_flags_register_q ^ $past(status_flags_register_q)) & 8'hF7) == 8'h00;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow op wrong");
	property p_sign;
		accept && op inside {OP_SET_SIGN_FLAG, OP_CLEAR_SIGN_FLAG} |=>
			status_flags_register_q[FLAG_S] == ($past(op) == OP_SET_SIGN_FLAG) &&
			((status_flags_register_q ^ $past(status_flags_register_q)) & 8'hEF) == 8'h00;
	endproperty
	a_sign: assert property (p_sign) else $error("sign op wrong");
	property p_post_inc_x;
		accept && op == OP_INDIRECT_LOAD_INC && ptr_sel == PTR_X && reg_sel < 5'h1A |=>
			dmem_re_q && dmem_addr_q == $past(x_ptr) ##1 done_q && x_ptr == $past(x_ptr, 2) + WORD_ONE;
	endproperty
	a_post_inc_x: assert property (p_post_inc_x) else $error("post increment wrong");
	property p_pre_dec_x;
		accept && op == OP_INDIRECT_STORE_DEC && ptr_sel == PTR_X |=>
			dmem_we_q && dmem_addr_q == $past(x_ptr) - WORD_ONE && x_ptr == dmem_addr_q;
	endproperty
	a_pre_dec_x: assert property (p_pre_dec_x) else $error("pre decrement wrong");
	property p_data_two_cycles;
		accept && is_data_op(op) && ptr_ok |=> busy_q && !done_q ##1 done_q && !busy_q &&
			$stable(status_flags_register_q);
	endproperty
	a_data_two_cycles: assert property (p_data_two_cycles) else $error("data op timing");
	property p_program_read;
		accept && op inside {[OP_PROGRAM_MEMORY_READ_ZERO:OP_PROGRAM_MEMORY_READ_INC]} |=>
			(pmem_re_q && !done_q) [*2] ##1 done_q && !pmem_re_q;
	endproperty
	a_program_read: assert property (p_program_read) else $error("program read timing");
	property p_push;
		accept && op == OP_PUSH |=> dmem_we_q && dmem_addr_q == $past(sp_q) &&
			sp_q == $past(sp_q) - WORD_ONE;
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_control;
		accept && op inside {OP_SLEEP, OP_WATCHDOG_RESTART} |=> (sleep_q ^ watchdog_restart_q) &&
			done_q && $stable(status_flags_register_q) ##1
			((!sleep_q && !watchdog_restart_q) || $past(accept));
	endproperty
	a_control: assert property (p_control) else $error("control pulse wrong");

	c_post_inc: cover property (accept && op == OP_INDIRECT_LOAD_INC ##2 done_q);
	c_program_read: cover property (accept && op == OP_PROGRAM_MEMORY_READ_INC ##3 done_q);
	c_push_pop: cover property (accept && op == OP_PUSH ##2 accept && op == OP_POP);
	c_displaced: cover property (accept && op == OP_DISPLACED_STORE && ptr_ok);
endmodule

/* verification/exec_mem_model.sv */
// data memory and program memory seen by the execution unit
module exec_mem_model (
	input wire logic clk,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_we,
	input wire logic dmem_re,
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_re,
	output logic [7:0] dmem_rdata,
	output logic [7:0] pmem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [256];
	logic [7:0] pbyte;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i * 7 + 3);
		end
	end
	always @(posedge clk) begin
		if (dmem_we) begin
			mem[dmem_addr[7:0]] <= dmem_wdata;
		end
	end
	// outside a read strobe the lines show garbage, not the last byte
	assign pbyte = pmem_addr[7:0] ^ pmem_addr[15:8] ^ 8'h5A;
	assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];
	assign pmem_rdata = pmem_re ? pbyte : ~pbyte;
endmodule

/* verification/bit_transfer_exec_tb_top.sv */
// self-checking bench for the flag, bit-move and data-transfer execution unit
module bit_transfer_exec_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import exec_pkg::*;
	logic clk, rst_n, ce, start, debug_en, host_wr_en, busy_q, done_q, illegal_q;
	logic dmem_we_q, dmem_re_q, pmem_re_q, sleep_q, watchdog_restart_q, break_q;
	op_type op;
	logic [4:0] reg_sel, host_wr_idx, peek_idx;
	logic [2:0] bit_sel;
	logic [1:0] ptr_sel;
	logic [5:0] disp;
	logic [15:0] direct_addr, sp_q, dmem_addr_q, pmem_addr_q;
	logic [7:0] host_wr_data, dmem_rdata, pmem_rdata, flags_q, peek_data_q, dmem_wdata_q;
	logic [7:0] m_reg [32];
	logic [7:0] m_mem [256];
	logic [7:0] m_fl;
	logic [15:0] m_sp;
	logic [31:0] seed;
	int fails, n_tests;

	bit_transfer_exec uut (.clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .op(op),
		.reg_sel(reg_sel), .bit_sel(bit_sel), .ptr_sel(ptr_sel), .disp(disp),
		.direct_addr(direct_addr), .debug_en(debug_en), .host_wr_en(host_wr_en),
		.host_wr_idx(host_wr_idx), .host_wr_data(host_wr_data), .peek_idx(peek_idx),
		.dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata), .busy_q(busy_q), .done_q(done_q),
		.illegal_q(illegal_q), .status_flags_register_q(flags_q), .sp_q(sp_q),
		.peek_data_q(peek_data_q), .dmem_addr_q(dmem_addr_q), .dmem_wdata_q(dmem_wdata_q),
		.dmem_we_q(dmem_we_q), .dmem_re_q(dmem_re_q), .pmem_addr_q(pmem_addr_q),
		.pmem_re_q(pmem_re_q), .sleep_q(sleep_q), .watchdog_restart_q(watchdog_restart_q),
		.break_q(break_q));
	exec_mem_model mem_model (.clk(clk), .dmem_addr(dmem_addr_q), .dmem_wdata(dmem_wdata_q),
		.dmem_we(dmem_we_q), .dmem_re(dmem_re_q), .pmem_addr(pmem_addr_q), .pmem_re(pmem_re_q),
		.dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata));

	////////////////////////////////////////////////////////////////////////////////
	function automatic int rnd(input int lim);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return int'(seed % lim);
	endfunction
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic host_wr(input int i, input logic [7:0] v);
		@(negedge clk);
		host_wr_en = 1'b1;
		host_wr_idx = 5'(i);
		host_wr_data = v;
		m_reg[i] = v;
		@(negedge clk);
		host_wr_en = 1'b0;
	endtask
	task automatic peek_chk(input int i);
		peek_idx = 5'(i);
		@(negedge clk);
		@(negedge clk);
		chk($sformatf("register %0d", i), {8'h00, m_reg[i]}, {8'h00, peek_data_q});
	endtask
	// model the operation first, then issue it and compare strobes, addresses, flags, stack pointer, timing, register r, the pointer pair and register 0
	task automatic run_op(input op_type o, input int r, input int b, input int p, input int d,
		input logic [15:0] da);
		logic [15:0] pv, a, wa, ra;
		logic [7:0] wd;
		logic ill, wr, rd, pm, seen;
		logic [2:0] pl, epl;
		int pa, cyc, n, nb, nr, np;
		pm = o inside {[OP_PROGRAM_MEMORY_READ_ZERO:OP_PROGRAM_MEMORY_READ_INC]};
		pa = pm ? 30 : (p == 3) ? 26 : 26 + 2 * p;
		pv = {m_reg[pa + 1], m_reg[pa]};
		ill = (o inside {[OP_INDIRECT_LOAD:OP_DISPLACED_STORE]} && p == 3) ||
			(o inside {OP_DISPLACED_LOAD, OP_DISPLACED_STORE} && p == 0);
		wr = o inside {[OP_INDIRECT_STORE:OP_DISPLACED_STORE], OP_DIRECT_STORE, OP_PUSH};
		rd = o inside {[OP_INDIRECT_LOAD:OP_DISPLACED_LOAD], OP_DIRECT_LOAD, OP_POP};
		cyc = pm ? 3 : (o inside {[OP_INDIRECT_LOAD:OP_DIRECT_STORE], OP_PUSH, OP_POP}) ? 2 : 1;
		epl = {o == OP_BREAK && debug_en, o == OP_WATCHDOG_RESTART, o == OP_SLEEP};
		a = pv;
		if (!ill) begin
			case (o)
				OP_BIT_TO_TRANSFER_FLAG: m_fl[6] = m_reg[r][b];
				OP_TRANSFER_FLAG_TO_BIT: m_reg[r][b] = m_fl[6];
				OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY: m_fl[5] = o == OP_SET_HALF_CARRY;
				OP_SET_OVERFLOW_FLAG, OP_CLEAR_OVERFLOW_FLAG: m_fl[3] = o == OP_SET_OVERFLOW_FLAG;
				OP_SET_SIGN_FLAG, OP_CLEAR_SIGN_FLAG: m_fl[4] = o == OP_SET_SIGN_FLAG;
				OP_INDIRECT_LOAD_INC, OP_INDIRECT_STORE_INC, OP_PROGRAM_MEMORY_READ_INC: pv++;
				OP_INDIRECT_LOAD_DEC, OP_INDIRECT_STORE_DEC: begin
					pv--;
					a = pv;
				end
				OP_DISPLACED_LOAD, OP_DISPLACED_STORE: a = pv + 16'(d);
				OP_DIRECT_LOAD, OP_DIRECT_STORE: a = da;
				OP_PUSH: begin
					a = m_sp;
					m_sp--;
				end
				OP_POP: begin
					m_sp++;
					a = m_sp;
				end
				default: ;
			endcase
			{m_reg[pa + 1], m_reg[pa]} = pv;
			if (wr) begin
				m_mem[a[7:0]] = m_reg[r];
			end else if (rd) begin
				m_reg[r] = m_mem[a[7:0]];
			end else if (pm) begin
				m_reg[o == OP_PROGRAM_MEMORY_READ_ZERO ? 0 : r] = a[7:0] ^ a[15:8] ^ 8'h5A;
			end
		end
		op = o;
		reg_sel = 5'(r);
		bit_sel = 3'(b);
		ptr_sel = 2'(p);
		disp = 6'(d);
		direct_addr = da;
		start = 1'b1;
		n = 0;
		nb = 0;
		nr = 0;
		np = 0;
		ra = 16'h0000;
		pl = 3'h0;
		seen = 1'b0;
		do begin
			@(negedge clk);
			start = 1'b0;
			n++;
			pl |= {break_q, watchdog_restart_q, sleep_q};
			nb += int'(busy_q === 1'b1);
			if (dmem_re_q === 1'b1 || pmem_re_q === 1'b1) begin
				nr += int'(dmem_re_q === 1'b1);
				np += int'(pmem_re_q === 1'b1);
				ra = (pmem_re_q === 1'b1) ? pmem_addr_q : dmem_addr_q;
			end
			if (dmem_we_q === 1'b1) begin
				seen = 1'b1;
				wa = dmem_addr_q;
				wd = dmem_wdata_q;
			end
		end while (done_q !== 1'b1 && illegal_q !== 1'b1 && n < 8);
		if (n >= 8) begin
			fails++;
			$display("wrong value completion expected pulse seen none");
			report_and_stop();
		end
		chk("illegal", 16'(ill), 16'(illegal_q));
		chk("cycles", 16'(ill ? 1 : cyc), 16'(n));
		chk("pulses", 16'(epl), 16'(pl));
		chk("flags", 16'(m_fl), 16'(flags_q));
		chk("stack pointer", m_sp, sp_q);
		chk("busy cycles", 16'(ill ? 0 : cyc - 1), 16'(nb));
		chk("write strobe", 16'(wr && !ill), 16'(seen));
		chk("read strobes", 16'(rd && !ill), 16'(nr));
		chk("program strobes", 16'(pm ? 2 : 0), 16'(np));
		if (seen) begin
			chk("write address", a, wa);
			chk("write data", 16'(m_reg[r]), 16'(wd));
		end
		if (nr + np > 0) begin
			chk("read address", a, ra);
		end
		peek_chk(r);
		peek_chk(pa);
		peek_chk(pa + 1);
		peek_chk(0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		int r;
		logic [15:0] da;
		{rst_n, start, debug_en, host_wr_en, reg_sel, host_wr_idx, peek_idx} = '0;
		{bit_sel, ptr_sel, disp, direct_addr, host_wr_data} = '0;
		op = OP_NOP;
		ce = 1'b1;
		seed = 32'h0001054A;
		fails = 0;
		n_tests = 0;
		m_fl = 8'h00;
		m_sp = 16'h00FF;
		for (int i = 0; i < 32; i++) m_reg[i] = 8'h00;
		for (int i = 0; i < 256; i++) m_mem[i] = 8'(i * 7 + 3);
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk("reset stack pointer", 16'h00FF, sp_q);
		chk("reset flags", 16'h0000, 16'(flags_q));
		for (int i = 0; i < 32; i++) host_wr(i, (i > 25 && i % 2 == 1) ? 8'h00 : 8'(rnd(256)));
		for (int j = 0; j < 2; j++) begin
			for (int k = 3 + j; k <= 8; k += 2) begin
				run_op(op_type'(k), 0, 0, 0, 0, 0);
			end
		end
		// a request held while the enable is low must change nothing
		ce = 1'b0;
		op = m_fl[FLAG_S] ? OP_CLEAR_SIGN_FLAG : OP_SET_SIGN_FLAG;
		start = 1'b1;
		repeat (2) @(negedge clk);
		chk("frozen flags", 16'(m_fl), 16'(flags_q));
		chk("frozen done", 16'h0000, 16'(done_q));
		start = 1'b0;
		ce = 1'b1;
		@(negedge clk);
		for (int i = 0; i < 6; i++) begin
			run_op(OP_BIT_TO_TRANSFER_FLAG, rnd(32), rnd(8), 0, 0, 0);
			run_op(OP_TRANSFER_FLAG_TO_BIT, rnd(26), rnd(8), 0, 0, 0);
		end
		for (int p = 0; p < 4; p++) begin
			for (int k = 9; k <= 16; k++) begin
				run_op(op_type'(k), rnd(26), 0, p, rnd(64), 0);
			end
		end
		host_wr(26, 8'hFF);
		host_wr(27, 8'h00);
		run_op(OP_INDIRECT_LOAD_INC, 3, 0, 0, 0, 0);
		run_op(OP_INDIRECT_STORE_DEC, 4, 0, 0, 0, 0);
		for (int i = 0; i < 3; i++) begin
			da = 16'(rnd(65536));
			r = rnd(26);
			run_op(OP_DIRECT_STORE, r, 0, 0, 0, da);
			run_op(OP_DIRECT_LOAD, (r + 1) % 26, 0, 0, 0, da);
			run_op(OP_PUSH, rnd(26), 0, 0, 0, 0);
		end
		for (int i = 0; i < 3; i++) run_op(OP_POP, rnd(26), 0, 0, 0, 0);
		host_wr(31, 8'h12);
		host_wr(30, 8'hFF);
		for (int k = 19; k <= 21; k++) begin
			run_op(op_type'(k), 1 + rnd(25), 0, 2, 0, 0);
		end
		for (int j = 0; j < 2; j++) begin
			debug_en = 1'(j);
			for (int i = 0; i < 4; i++) begin
				run_op(op_type'(i == 0 ? 0 : 23 + i), 0, 0, 0, 0, 0);
			end
		end
		report_and_stop();
	end
endmodule
